// ===== include/term_timing_pkg.sv
// constants for the termination and write leveling timing block
package term_timing_pkg;
    // ----------------------------------------
    // clock
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    // ----------------------------------------
    // termination hold, skew, leveling and relock counts, in clock cycles
    // ----------------------------------------
    localparam int TERM_HIGH_MIN_LONG_BURST = 6;
    localparam int TERM_HIGH_MIN_SHORT_BURST = 4;
    localparam int NOMINAL_TO_WRITE_SKEW_SUB = 2;
    localparam int WRITE_TO_NOMINAL_CHOP_CK = 4;
    localparam int WRITE_TO_NOMINAL_FULL_CK = 6;
    localparam int LEVEL_ENABLE_TO_FIRST_STROBE = 40;
    localparam int DLL_RELOCK_EXIT_CK = 10;
    // ----------------------------------------
    // nanosecond limits, in picoseconds as printed
    // ----------------------------------------
    localparam int ASYNC_TERM_OFF_MIN_PS = 2000;
    localparam int ASYNC_TERM_OFF_MAX_PS = 8500;
    localparam int LEVEL_FEEDBACK_DELAY_MAX_PS = 9000;
    localparam int LEVEL_FEEDBACK_ERROR_MAX_PS = 2000;
    // minimum rounds up, maximum rounds down, ASYNC_OFF_CYC and FEEDBACK_CYC floored at one cycle
    localparam int ASYNC_OFF_MIN_CYC_RAW = (ASYNC_TERM_OFF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_MAX_CYC_RAW = ASYNC_TERM_OFF_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_OFF_CYC = (ASYNC_OFF_MIN_CYC_RAW < 1) ? 1 : ASYNC_OFF_MIN_CYC_RAW;
    localparam int FEEDBACK_MAX_CYC_RAW = LEVEL_FEEDBACK_DELAY_MAX_PS / CLK_PERIOD_PS;
    localparam int FEEDBACK_CYC = (FEEDBACK_MAX_CYC_RAW < 1) ? 1 : FEEDBACK_MAX_CYC_RAW;
    // ----------------------------------------
    // termination state codes and widths
    // ----------------------------------------
    localparam int LAT_W = 5;
    localparam logic [1:0] TERM_OFF = 2'h0;
    localparam logic [1:0] TERM_NOMINAL = 2'h1;
    localparam logic [1:0] TERM_WRITE = 2'h3;
endpackage : term_timing_pkg

// ===== src/term_delay_line.sv
// shift register delaying the write-termination window by a programmable count
`timescale 1ns/1ps
module term_delay_line #(
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_bit,
    input wire logic [4:0] tap,
    output logic out_bit
);
    logic [DEPTH-1:0] line_q;
    logic [DEPTH-1:0] line_d;
    logic out_d;
    logic out_q;

    // shift in and pick the tap
    always_comb begin
        line_d = {line_q[DEPTH-2:0], in_bit};
        out_d = line_q[tap];
    end

    // register line and selected output
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= '0;
            out_q <= 1'b0;
        end else begin
            line_q <= line_d;
            out_q <= out_d;
        end
    end

    assign out_bit = out_q;
endmodule : term_delay_line

// ===== src/term_level_timing.sv
// device-side termination switching and write leveling feedback timing
// Operation
// - write termination starts write latency minus two cycles after the write.
// - chop write returns to nominal four cycles plus turn-off latency after reference.
// - full write returns to nominal six cycles plus turn-off latency after reference.
// - asynchronous termination turns off between two and eight and a half ns; the code drops it one 25 ns clock after the synchronised control falls.
// - leveling feedback appears within nine ns of each strobe rising edge; the code shows it two 25 ns clocks after the synchronised edge.
// - leveling feedback may be uncertain up to two ns before settling.
// - cycle limits count actual clock periods, one per edge.
// - turn-off spans from starting removal until the buffer is high impedance.
`timescale 1ns/1ps
module term_level_timing #(
    parameter int LAT_W = term_timing_pkg::LAT_W
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic term_ctl,
    input wire logic write_cmd,
    input wire logic write_chop,
    input wire logic dll_off_pd,
    input wire logic dyn_term_en,
    input wire logic [LAT_W-1:0] write_latency,
    input wire logic [LAT_W-1:0] sync_term_off_latency,
    input wire logic level_en,
    input wire logic strobe,
    input wire logic clk_level,
    output logic [1:0] term_state,
    output logic term_hiz,
    output logic level_feedback,
    output logic level_feedback_valid
);
    // ----------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // two flops on each of the seven control inputs; dyn_term_en and the latency inputs are used unsynchronised
    localparam int NIN = 7;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    assign raw_in = {term_ctl, write_cmd, write_chop, dll_off_pd, level_en, strobe, clk_level};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
        end
    end
    logic ctl_s, wr_s, chop_s, pd_s, lvl_s, dqs_s, ck_s;
    assign {ctl_s, wr_s, chop_s, pd_s, lvl_s, dqs_s, ck_s} = s2_q;

    // ----------------------------------------
    // dynamic termination sequencing
    // ----------------------------------------
    logic [LAT_W-1:0] on_tap;
    logic [4:0] on_tap5;
    logic [4:0] hold_len;
    logic chop_len_q, chop_len_d;
    logic wr_fire;
    logic wr_window;
    // start skew is write latency minus two, floored at zero
    assign on_tap = (write_latency > LAT_W'(term_timing_pkg::NOMINAL_TO_WRITE_SKEW_SUB)) ?
        write_latency - LAT_W'(term_timing_pkg::NOMINAL_TO_WRITE_SKEW_SUB) : '0;
    assign on_tap5 = 5'(on_tap);
    assign wr_fire = wr_s & ctl_s & dyn_term_en;

    term_delay_line #(.DEPTH(32)) u_delay (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_bit(wr_fire),
        .tap(on_tap5),
        .out_bit(wr_window)
    );

    // window length: 4 or 6 cycles plus turn-off latency after reference point
    assign hold_len = chop_len_q ? 5'(term_timing_pkg::WRITE_TO_NOMINAL_CHOP_CK) + 5'(sync_term_off_latency)
                                 : 5'(term_timing_pkg::WRITE_TO_NOMINAL_FULL_CK) + 5'(sync_term_off_latency);

    logic [4:0] wcnt_q, wcnt_d;
    logic [1:0] term_q, term_d;
    logic hiz_q, hiz_d;
    logic [3:0] aoff_q, aoff_d;

    // next termination state
    always_comb begin
        chop_len_d = chop_len_q;
        wcnt_d = wcnt_q;
        term_d = term_q;
        hiz_d = hiz_q;
        aoff_d = aoff_q;
        if (wr_fire) begin
            chop_len_d = chop_s;
        end
        if (wr_window) begin
            wcnt_d = hold_len;
        end else if (wcnt_q != 5'h00) begin
            wcnt_d = wcnt_q - 5'h01;
        end
        if (pd_s) begin
            // asynchronous path: drop after fixed off delay
            if (ctl_s) begin
                aoff_d = 4'(term_timing_pkg::ASYNC_OFF_CYC);
                term_d = term_timing_pkg::TERM_NOMINAL;
                hiz_d = 1'b0;
            end else if (aoff_q > 4'h1) begin
                aoff_d = aoff_q - 4'h1;
            end else begin
                aoff_d = 4'h0;
                term_d = term_timing_pkg::TERM_OFF;
                hiz_d = 1'b1;
            end
        end else begin
            aoff_d = 4'h0;
            if (wr_window || (wcnt_q > 5'h01)) begin
                term_d = term_timing_pkg::TERM_WRITE;
                hiz_d = 1'b0;
            end else if (ctl_s) begin
                term_d = term_timing_pkg::TERM_NOMINAL;
                hiz_d = 1'b0;
            end else begin
                term_d = term_timing_pkg::TERM_OFF;
                hiz_d = 1'b1;
            end
        end
    end

    // register termination state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_len_q <= 1'b0;
            wcnt_q <= 5'h00;
            term_q <= term_timing_pkg::TERM_OFF;
            hiz_q <= 1'b1;
            aoff_q <= 4'h0;
        end else begin
            chop_len_q <= chop_len_d;
            wcnt_q <= wcnt_d;
            term_q <= term_d;
            hiz_q <= hiz_d;
            aoff_q <= aoff_d;
        end
    end
    assign term_state = term_q;
    assign term_hiz = hiz_q;

    // ----------------------------------------
    // write leveling feedback
    // ----------------------------------------
    typedef enum logic [1:0] {LV_IDLE = 2'h0, LV_WAIT = 2'h1, LV_SHOW = 2'h3} lv_state_t;
    lv_state_t lv_q, lv_d;
    logic dqs_prev_q, dqs_prev_d;
    logic fb_q, fb_d;
    logic fbv_q, fbv_d;
    logic [3:0] fcnt_q, fcnt_d;
    logic samp_q, samp_d;

    // sample clock level on strobe rise, show after fixed delay
    always_comb begin
        lv_d = lv_q;
        dqs_prev_d = dqs_s;
        fb_d = fb_q;
        fbv_d = fbv_q;
        fcnt_d = fcnt_q;
        samp_d = samp_q;
        unique case (lv_q)
            LV_IDLE: begin
                fbv_d = 1'b0;
                if (lvl_s && dqs_s && !dqs_prev_q) begin
                    samp_d = ck_s;
                    fcnt_d = 4'(term_timing_pkg::FEEDBACK_CYC);
                    lv_d = LV_WAIT;
                end
            end
            LV_WAIT: begin
                // output held invalid through the error window
                fbv_d = 1'b0;
                if (fcnt_q > 4'h1) begin
                    fcnt_d = fcnt_q - 4'h1;
                end else begin
                    fb_d = samp_q;
                    fbv_d = 1'b1;
                    lv_d = LV_SHOW;
                end
            end
            LV_SHOW: begin
                if (!lvl_s) begin
                    fbv_d = 1'b0;
                    lv_d = LV_IDLE;
                end else if (dqs_s && !dqs_prev_q) begin
                    // drop valid so the error window never shows as settled
                    fbv_d = 1'b0;
                    samp_d = ck_s;
                    fcnt_d = 4'(term_timing_pkg::FEEDBACK_CYC);
                    lv_d = LV_WAIT;
                end
            end
            default: lv_d = LV_IDLE;
        endcase
    end

    // register leveling state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lv_q <= LV_IDLE;
            dqs_prev_q <= 1'b0;
            fb_q <= 1'b0;
            fbv_q <= 1'b0;
            fcnt_q <= 4'h0;
            samp_q <= 1'b0;
        end else begin
            lv_q <= lv_d;
            dqs_prev_q <= dqs_prev_d;
            fb_q <= fb_d;
            fbv_q <= fbv_d;
            fcnt_q <= fcnt_d;
            samp_q <= samp_d;
        end
    end
    assign level_feedback = fb_q;
    assign level_feedback_valid = fbv_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_write_term_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_window && !pd_s) |=> term_q == term_timing_pkg::TERM_WRITE)
        else $error("write termination not entered");
    a_window_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_window && !chop_len_q) |=> wcnt_q == 5'(term_timing_pkg::WRITE_TO_NOMINAL_FULL_CK) + 5'(sync_term_off_latency))
        else $error("full burst window length wrong");
    a_chop_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_window && chop_len_q) |=> wcnt_q == 5'(term_timing_pkg::WRITE_TO_NOMINAL_CHOP_CK) + 5'(sync_term_off_latency))
        else $error("chop window length wrong");
    a_async_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pd_s && !ctl_s)[*3] |=> hiz_q && term_q == term_timing_pkg::TERM_OFF)
        else $error("async termination not off in time");
    a_hiz_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hiz_q |-> term_q == term_timing_pkg::TERM_OFF)
        else $error("high impedance with termination on");
    a_feedback_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (lv_q != LV_WAIT && lvl_s && dqs_s && !dqs_prev_q) |=> ##[0:1] fbv_q)
        else $error("leveling feedback late");
    a_feedback_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (lv_q == LV_WAIT) |-> !fbv_q)
        else $error("feedback valid inside error window");
endmodule : term_level_timing

// ===== bench/ctl_model.sv
// controller-side model driving termination, write commands and leveling strobes
`timescale 1ns/1ps
module ctl_model (
    input wire logic sys_clk,
    output logic term_ctl,
    output logic write_cmd,
    output logic write_chop,
    output logic level_en,
    output logic strobe,
    output logic clk_level
);
    // idle levels at time zero
    initial begin
        term_ctl = 1'b0;
        write_cmd = 1'b0;
        write_chop = 1'b0;
        level_en = 1'b0;
        strobe = 1'b0;
        clk_level = 1'b0;
    end
    // termination level, held at least the longest minimum high time
    task automatic term_set(input logic v);
        @(posedge sys_clk) term_ctl <= v;
        repeat (term_timing_pkg::TERM_HIGH_MIN_LONG_BURST) @(posedge sys_clk);
    endtask : term_set
    // one write pulse; burst kind line released to the inverse afterwards
    task automatic write_burst(input logic chop);
        @(posedge sys_clk);
        write_cmd <= 1'b1;
        write_chop <= chop;
        @(posedge sys_clk);
        write_cmd <= 1'b0;
        write_chop <= ~chop;
        // same settle time for both burst kinds, so start skews compare directly
        repeat (term_timing_pkg::TERM_HIGH_MIN_LONG_BURST) @(posedge sys_clk);
    endtask : write_burst
    // leveling enable, then the wait before any strobe edge
    task automatic level_set(input logic v);
        @(posedge sys_clk) level_en <= v;
        repeat (term_timing_pkg::LEVEL_ENABLE_TO_FIRST_STROBE) @(posedge sys_clk);
    endtask : level_set
    // one strobe pulse with the clock level presented to the sampler
    task automatic strobe_pulse(input logic v);
        @(posedge sys_clk);
        clk_level <= v;
        strobe <= 1'b1;
        repeat (2) @(posedge sys_clk);
        strobe <= 1'b0;
        clk_level <= ~v;
    endtask : strobe_pulse
    // change the termination level at the next edge, with no hold after
    task automatic term_now(input logic v);
        @(posedge sys_clk) term_ctl <= v;
    endtask : term_now
    // change the leveling enable at the next edge, with no hold after
    task automatic level_now(input logic v);
        @(posedge sys_clk) level_en <= v;
    endtask : level_now
endmodule : ctl_model

// ===== bench/term_level_timing_tb_top.sv
// self-checking bench for the termination and leveling timing block
`timescale 1ns/1ps
module term_level_timing_tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic dll_off_pd = 1'b0;
    logic dyn_term_en = 1'b1;
    logic [4:0] write_latency = 5'h06;
    logic [4:0] sync_term_off_latency = 5'h03;
    logic term_ctl, write_cmd, write_chop, level_en, strobe, clk_level;
    logic [1:0] term_state;
    logic term_hiz, level_feedback, level_feedback_valid;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    // ----------------------------------------
    // clock, timeout, instances
    // ----------------------------------------
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end
    ctl_model ctl_u (.sys_clk(sys_clk), .term_ctl(term_ctl), .write_cmd(write_cmd), .write_chop(write_chop),
        .level_en(level_en), .strobe(strobe), .clk_level(clk_level));
    term_level_timing dut_u (.sys_clk(sys_clk), .resetn(resetn), .term_ctl(term_ctl), .write_cmd(write_cmd),
        .write_chop(write_chop), .dll_off_pd(dll_off_pd), .dyn_term_en(dyn_term_en),
        .write_latency(write_latency), .sync_term_off_latency(sync_term_off_latency), .level_en(level_en),
        .strobe(strobe), .clk_level(clk_level), .term_state(term_state), .term_hiz(term_hiz),
        .level_feedback(level_feedback), .level_feedback_valid(level_feedback_valid));
    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic bad(input logic [31:0] got, input logic [31:0] exp);
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    endtask : bad
    task automatic chk_state(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) bad(32'(got), 32'(exp));
    endtask : chk_state
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) bad(32'(got), 32'(exp));
    endtask : chk_bit
    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) bad(got, exp);
    endtask : chk_cnt
    task automatic stop_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // one write; cycles until write termination, then cycles it stands
    task automatic run_write(input logic chop, output int start, output int len);
        ctl_u.write_burst(chop);
        #1 start = 0;
        len = 0;
        while (term_state !== term_timing_pkg::TERM_WRITE && start < 40) begin
            @(posedge sys_clk) #1;
            start++;
        end
        while (term_state === term_timing_pkg::TERM_WRITE && len < 40) begin
            @(posedge sys_clk) #1;
            len++;
        end
    endtask : run_write
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_dyn_write();
        int s6, s8, len;
        ctl_u.term_set(1'b1);
        #1 chk_state(term_state, term_timing_pkg::TERM_NOMINAL);
        run_write(1'b0, s6, len);
        chk_cnt(len, term_timing_pkg::WRITE_TO_NOMINAL_FULL_CK + 3);
        chk_state(term_state, term_timing_pkg::TERM_NOMINAL);
        @(posedge sys_clk) write_latency <= 5'h08;
        run_write(1'b1, s8, len);
        chk_cnt(len, term_timing_pkg::WRITE_TO_NOMINAL_CHOP_CK + 3);
        chk_cnt(s8 - s6, 2);
    endtask : test_dyn_write
    task automatic test_refused();
        int s, len;
        ctl_u.term_set(1'b0);
        #1 chk_state(term_state, term_timing_pkg::TERM_OFF);
        run_write(1'b0, s, len);
        chk_cnt(len, 0);
        ctl_u.term_set(1'b1);
        @(posedge sys_clk) dyn_term_en <= 1'b0;
        run_write(1'b0, s, len);
        chk_cnt(len, 0);
        @(posedge sys_clk) dyn_term_en <= 1'b1;
    endtask : test_refused
    task automatic test_power_down();
        int n;
        @(posedge sys_clk) dll_off_pd <= 1'b1;
        ctl_u.term_set(1'b1);
        #1 chk_bit(term_hiz, 1'b0);
        ctl_u.term_now(1'b0);
        #1 n = 0;
        while (term_hiz !== 1'b1 && n < 20) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk_bit(n <= term_timing_pkg::ASYNC_OFF_CYC + 3, 1'b1);
        chk_state(term_state, term_timing_pkg::TERM_OFF);
        @(posedge sys_clk) dll_off_pd <= 1'b0;
        // relock time before any synchronous termination change
        repeat (term_timing_pkg::DLL_RELOCK_EXIT_CK) @(posedge sys_clk);
    endtask : test_power_down
    task automatic test_level();
        ctl_u.level_set(1'b1);
        for (int i = 0; i < 3; i++) begin
            ctl_u.strobe_pulse(i[0] ? 1'b0 : 1'b1);
            repeat (term_timing_pkg::FEEDBACK_CYC + 4) @(posedge sys_clk);
            #1 chk_bit(level_feedback_valid, 1'b1);
            chk_bit(level_feedback, i[0] ? 1'b0 : 1'b1);
        end
        ctl_u.level_now(1'b0);
        repeat (4) @(posedge sys_clk);
        #1 chk_bit(level_feedback_valid, 1'b0);
    endtask : test_level
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk_bit(term_hiz, 1'b1);
        test_dyn_write();
        test_refused();
        test_power_down();
        test_level();
        stop_test();
    end
endmodule : term_level_timing_tb_top
